// File: rts_defs.svh
`ifndef RTS_DEFS_SVH
`define RTS_DEFS_SVH

// clock period and the two rounding forms used for every delay
`define RTS_CLK_NS 10
`define RTS_CYC_MIN(ns) (((ns) + `RTS_CLK_NS - 1) / `RTS_CLK_NS)
`define RTS_CYC_MAX(ns) ((ns) / `RTS_CLK_NS)

// timer geometry
`define RTS_TMR_W 10
`define RTS_TMR_N 4
`define RTS_TMR_CMD 0
`define RTS_TMR_STS 1
`define RTS_TMR_WSYNC 2
`define RTS_TMR_WPAR 3

// times in ns, 12 MHz mode then 16 MHz mode
`define RTS_T_START_12_NS 970
`define RTS_T_START_16_NS 870
`define RTS_T_STRB_W_12_NS 140
`define RTS_T_STRB_W_16_NS 100
`define RTS_T_ADDR_12_NS 300
`define RTS_T_ADDR_16_NS 220
`define RTS_T_INPROG_12_NS 800
`define RTS_T_INPROG_16_NS 590
`define RTS_T_CNT_NS 5
`define RTS_T_CMDXFER_12_NS 1190
`define RTS_T_CMDXFER_16_NS 880
`define RTS_T_STS_IN_NS 4100
`define RTS_T_SIX_RISE_NS 3000
`define RTS_T_WR_RISE_12_NS 920
`define RTS_T_WR_RISE_16_NS 840
`define RTS_T_TXXFER_12_NS 1700
`define RTS_T_TXXFER_16_NS 1430
`define RTS_T_WR_FALL_12_NS 965
`define RTS_T_WR_FALL_16_NS 880
`define RTS_T_TXEND_12_NS 1010
`define RTS_T_TXEND_16_NS 910
`define RTS_T_RXXFER_12_NS 1520
`define RTS_T_RXXFER_16_NS 1230
`define RTS_T_RXEND_12_NS 3360
`define RTS_T_RXEND_16_NS 3260
`define RTS_T_BLK_12_NS 3230
`define RTS_T_BLK_16_NS 3170
`define RTS_T_BLK_W_12_NS 140
`define RTS_T_BLK_W_16_NS 100

// reset values
`define RTS_RST_ADDR 14'h3FFF
`define RTS_RST_CNT 5'h00

`endif

// File: rts_pkg.sv
`include "rts_defs.svh"
package rts_pkg;

  typedef enum logic [1:0] {
    RTS_ST_IDLE = 2'b01,
    RTS_ST_MSG = 2'b10
  } rts_state_type;

  typedef logic [`RTS_TMR_W-1:0] rts_tmr_type;

endpackage

// File: rts_sequencer.sv
`timescale 1ns/100ps
`include "rts_defs.svh"
module rts_sequencer #(
  parameter int ADDR_W = 14,
  parameter int CNT_W = 5
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic mode_16mhz_i,
  input wire logic cmd_parity_mid_i,
  input wire logic cmd_transmit_i,
  input wire logic [CNT_W-1:0] cmd_word_count_i,
  input wire logic [ADDR_W-1:0] sub_address_i,
  input wire logic status_sync_mid_i,
  input wire logic status_parity_mid_i,
  input wire logic word_sync_mid_i,
  input wire logic word_parity_mid_i,
  input wire logic last_word_i,
  input wire logic rx_good_i,
  input wire logic term_fail_i,
  input wire logic busy_i,
  input wire logic service_request_i,
  input wire logic subsystem_flag_i,
  input wire logic transfer_grant_n_i,
  input wire logic address_float_select_i,
  output logic message_start_strobe_n_o,
  output logic message_in_progress_n_o,
  output logic [ADDR_W-1:0] address_o,
  output logic address_oe_n_o,
  output logic [CNT_W-1:0] current_word_count_o,
  output logic transfer_request_n_o,
  output logic chip_select_n_o,
  output logic write_strobe_o,
  output logic strobe_oe_n_o,
  output logic terminal_fail_flag_o,
  output logic good_block_received_n_o,
  output logic [2:0] status_bits_o
);

  localparam int SIX_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // delay selection by clock mode

  function automatic rts_pkg::rts_tmr_type sel(input logic m16, input int c12, input int c16);
    sel = m16 ? rts_pkg::rts_tmr_type'(c16) : rts_pkg::rts_tmr_type'(c12);
  endfunction

  rts_pkg::rts_tmr_type c_fall, c_rise, c_addr, c_inp, c_cnt, c_cmdx, c_sts, c_six;
  rts_pkg::rts_tmr_type c_wrr, c_txx, c_wrf, c_txe, c_rxx, c_rxe, c_blk, c_blke;

  always_comb begin
    c_fall = sel(mode_16mhz_i, `RTS_CYC_MIN(`RTS_T_START_12_NS),
                 `RTS_CYC_MIN(`RTS_T_START_16_NS));
    c_rise = c_fall + sel(mode_16mhz_i, `RTS_CYC_MIN(`RTS_T_STRB_W_12_NS),
                          `RTS_CYC_MIN(`RTS_T_STRB_W_16_NS));
    c_addr = c_fall + sel(mode_16mhz_i, `RTS_CYC_MIN(`RTS_T_ADDR_12_NS),
                          `RTS_CYC_MIN(`RTS_T_ADDR_16_NS));
    c_inp = c_fall + sel(mode_16mhz_i, `RTS_CYC_MIN(`RTS_T_INPROG_12_NS),
                         `RTS_CYC_MIN(`RTS_T_INPROG_16_NS));
    c_cnt = c_inp + rts_pkg::rts_tmr_type'(`RTS_CYC_MIN(`RTS_T_CNT_NS));
    c_cmdx = c_fall + sel(mode_16mhz_i, `RTS_CYC_MIN(`RTS_T_CMDXFER_12_NS),
                          `RTS_CYC_MIN(`RTS_T_CMDXFER_16_NS));
    c_sts = c_fall + rts_pkg::rts_tmr_type'(`RTS_CYC_MAX(`RTS_T_STS_IN_NS));
    c_six = c_rise + rts_pkg::rts_tmr_type'(`RTS_CYC_MIN(`RTS_T_SIX_RISE_NS));
    c_wrr = sel(mode_16mhz_i, `RTS_CYC_MIN(`RTS_T_WR_RISE_12_NS),
                `RTS_CYC_MIN(`RTS_T_WR_RISE_16_NS));
    c_txx = sel(mode_16mhz_i, `RTS_CYC_MIN(`RTS_T_TXXFER_12_NS),
                `RTS_CYC_MIN(`RTS_T_TXXFER_16_NS));
    c_wrf = sel(mode_16mhz_i, `RTS_CYC_MIN(`RTS_T_WR_FALL_12_NS),
                `RTS_CYC_MIN(`RTS_T_WR_FALL_16_NS));
    c_txe = sel(mode_16mhz_i, `RTS_CYC_MIN(`RTS_T_TXEND_12_NS),
                `RTS_CYC_MIN(`RTS_T_TXEND_16_NS));
    c_rxx = sel(mode_16mhz_i, `RTS_CYC_MIN(`RTS_T_RXXFER_12_NS),
                `RTS_CYC_MIN(`RTS_T_RXXFER_16_NS));
    c_rxe = sel(mode_16mhz_i, `RTS_CYC_MIN(`RTS_T_RXEND_12_NS),
                `RTS_CYC_MIN(`RTS_T_RXEND_16_NS));
    c_blk = sel(mode_16mhz_i, `RTS_CYC_MIN(`RTS_T_BLK_12_NS),
                `RTS_CYC_MIN(`RTS_T_BLK_16_NS));
    c_blke = c_blk + sel(mode_16mhz_i, `RTS_CYC_MIN(`RTS_T_BLK_W_12_NS),
                         `RTS_CYC_MIN(`RTS_T_BLK_W_16_NS));
  end

  ////////////////////////////////////////////////////////////////////////////
  // event timers: 0 = idle, start loads 1, counts up and saturates

  rts_pkg::rts_state_type st_r, st_nxt;
  logic tx_r, tx_nxt;
  logic [`RTS_TMR_N-1:0] tstart;
  rts_pkg::rts_tmr_type tmr_r [`RTS_TMR_N];
  rts_pkg::rts_tmr_type tmr_nxt [`RTS_TMR_N];

  always_comb begin
    tstart = '0;
    tstart[`RTS_TMR_CMD] = (st_r == rts_pkg::RTS_ST_IDLE) && cmd_parity_mid_i;
    tstart[`RTS_TMR_STS] = tx_r ? status_sync_mid_i : status_parity_mid_i;
    tstart[`RTS_TMR_WSYNC] = word_sync_mid_i;
    tstart[`RTS_TMR_WPAR] = word_parity_mid_i;
  end

  genvar g;
  generate
    for (g = 0; g < `RTS_TMR_N; g++) begin : gen_tmr
      always_comb begin
        tmr_nxt[g] = tmr_r[g];
        if (tstart[g]) begin
          tmr_nxt[g] = rts_pkg::rts_tmr_type'(1);
        end else if (tmr_r[g] != '0 && tmr_r[g] != '1) begin
          tmr_nxt[g] = tmr_r[g] + rts_pkg::rts_tmr_type'(1);
        end
      end
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          tmr_r[g] <= '0;
        end else begin
          tmr_r[g] <= tmr_nxt[g];
        end
      end
    end
  endgenerate

  wire rts_pkg::rts_tmr_type tc = tmr_r[`RTS_TMR_CMD];
  wire rts_pkg::rts_tmr_type ts = tmr_r[`RTS_TMR_STS];
  wire rts_pkg::rts_tmr_type tw = tmr_r[`RTS_TMR_WSYNC];
  wire rts_pkg::rts_tmr_type tp = tmr_r[`RTS_TMR_WPAR];

  ////////////////////////////////////////////////////////////////////////////
  // message sequencing

  logic strb_n_r, strb_n_nxt;
  logic inp_n_r, inp_n_nxt;
  logic six_r, six_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic req_n_r, req_n_nxt;
  logic xcmd_r, xcmd_nxt;
  logic wr_r, wr_nxt;
  logic fail_r, fail_nxt;
  logic blk_n_r, blk_n_nxt;
  logic good_r, good_nxt;
  logic last_r, last_nxt;
  logic [2:0] sts_r, sts_nxt;
  logic xfer_go;

  always_comb begin
    st_nxt = st_r;
    tx_nxt = tx_r;
    strb_n_nxt = strb_n_r;
    inp_n_nxt = inp_n_r;
    six_nxt = six_r;
    addr_nxt = addr_r;
    cnt_nxt = cnt_r;
    req_n_nxt = req_n_r;
    xcmd_nxt = xcmd_r;
    wr_nxt = wr_r;
    fail_nxt = fail_r;
    blk_n_nxt = blk_n_r;
    good_nxt = good_r;
    last_nxt = last_r;
    sts_nxt = sts_r;
    xfer_go = 1'b0;
    // transfer ends once the subsystem has granted; request rise closes it
    if (!req_n_r && !transfer_grant_n_i) begin
      req_n_nxt = 1'b1;
      xcmd_nxt = 1'b0;
      if (!xcmd_r && cnt_r != '0) begin
        cnt_nxt = cnt_r - CNT_W'(1);
      end
    end
    // good block pulse may outlast the return to idle
    if (!tx_r && good_r && ts == c_blk) begin
      blk_n_nxt = 1'b0;
    end
    if (ts == c_blke) begin
      blk_n_nxt = 1'b1;
    end
    unique case (st_r)
      rts_pkg::RTS_ST_IDLE: begin
        if (cmd_parity_mid_i) begin
          st_nxt = rts_pkg::RTS_ST_MSG;
          tx_nxt = cmd_transmit_i;
          good_nxt = 1'b0;
          last_nxt = 1'b0;
          fail_nxt = 1'b0;
        end
      end
      rts_pkg::RTS_ST_MSG: begin
        if (tc == c_fall) begin
          strb_n_nxt = 1'b0;
        end
        if (tc == c_rise) begin
          strb_n_nxt = 1'b1;
          six_nxt = 1'b0;
        end
        if (tc == c_addr) begin
          addr_nxt = sub_address_i;
          addr_nxt[SIX_BIT] = six_r;
        end
        if (tc == c_inp) begin
          inp_n_nxt = 1'b0;
        end
        if (tc == c_cnt) begin
          cnt_nxt = cmd_word_count_i;
        end
        if (tx_r && tc == c_cmdx) begin
          xfer_go = 1'b1;
          xcmd_nxt = 1'b1;
        end
        // sampled at the latest valid point; subsystem holds 500 ns after
        if (tc == c_sts) begin
          sts_nxt = {busy_i, service_request_i, subsystem_flag_i};
        end
        // late release, held off while the command word transfer is still open
        if (tx_r && !six_r && tc >= c_six && req_n_r && !xfer_go) begin
          six_nxt = 1'b1;
        end
        if (status_sync_mid_i) begin
          fail_nxt = term_fail_i;
        end
        if (tx_r && ts == c_wrr) begin
          wr_nxt = 1'b1;
        end
        if (tx_r && (ts == c_txx || (tw == c_txx && !last_r))) begin
          xfer_go = 1'b1;
        end
        if (word_sync_mid_i) begin
          last_nxt = last_word_i;
        end
        if (!tx_r && tp == c_rxx) begin
          xfer_go = 1'b1;
        end
        if (tx_r && last_r && tw == c_wrf) begin
          wr_nxt = 1'b0;
        end
        if (tx_r && last_r && tp == c_txe) begin
          inp_n_nxt = 1'b1;
          st_nxt = rts_pkg::RTS_ST_IDLE;
        end
        if (!tx_r && status_parity_mid_i) begin
          good_nxt = rx_good_i;
        end
        if (!tx_r && ts == c_rxe) begin
          inp_n_nxt = 1'b1;
          st_nxt = rts_pkg::RTS_ST_IDLE;
        end
        if (st_nxt == rts_pkg::RTS_ST_IDLE) begin
          six_nxt = 1'b1;
          strb_n_nxt = 1'b1;
          wr_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = rts_pkg::RTS_ST_IDLE;
      end
    endcase
    // a new cycle only opens once the previous request has risen
    if (xfer_go && req_n_r) begin
      req_n_nxt = 1'b0;
    end
    addr_nxt[SIX_BIT] = six_nxt;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= rts_pkg::RTS_ST_IDLE;
      tx_r <= 1'b0;
      strb_n_r <= 1'b1;
      inp_n_r <= 1'b1;
      six_r <= 1'b1;
      addr_r <= `RTS_RST_ADDR;
      cnt_r <= `RTS_RST_CNT;
      req_n_r <= 1'b1;
      xcmd_r <= 1'b0;
      wr_r <= 1'b0;
      fail_r <= 1'b0;
      blk_n_r <= 1'b1;
      good_r <= 1'b0;
      last_r <= 1'b0;
      sts_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      tx_r <= tx_nxt;
      strb_n_r <= strb_n_nxt;
      inp_n_r <= inp_n_nxt;
      six_r <= six_nxt;
      addr_r <= addr_nxt;
      cnt_r <= cnt_nxt;
      req_n_r <= req_n_nxt;
      xcmd_r <= xcmd_nxt;
      wr_r <= wr_nxt;
      fail_r <= fail_nxt;
      blk_n_r <= blk_n_nxt;
      good_r <= good_nxt;
      last_r <= last_nxt;
      sts_r <= sts_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; enables are combinational so the bus frees with the grant

  assign message_start_strobe_n_o = strb_n_r;
  assign message_in_progress_n_o = inp_n_r;
  assign address_o = addr_r;
  assign current_word_count_o = cnt_r;
  assign transfer_request_n_o = req_n_r;
  assign chip_select_n_o = req_n_r | transfer_grant_n_i;
  assign write_strobe_o = wr_r;
  assign terminal_fail_flag_o = fail_r;
  assign good_block_received_n_o = blk_n_r;
  assign status_bits_o = sts_r;
  assign address_oe_n_o = address_float_select_i & transfer_grant_n_i;
  assign strobe_oe_n_o = address_float_select_i & transfer_grant_n_i;

endmodule

// File: rts_props_properties.sv
`timescale 1ns/100ps
module rts_props (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic mode_16mhz_i,
  input wire logic cmd_parity_mid_i,
  input wire logic status_sync_mid_i,
  input wire logic term_fail_i,
  input wire logic [4:0] cmd_word_count_i,
  input wire logic transfer_grant_n_i,
  input wire logic address_float_select_i,
  input wire logic message_start_strobe_n_o,
  input wire logic message_in_progress_n_o,
  input wire logic [13:0] address_o,
  input wire logic address_oe_n_o,
  input wire logic [4:0] current_word_count_o,
  input wire logic transfer_request_n_o,
  input wire logic chip_select_n_o,
  input wire logic strobe_oe_n_o,
  input wire logic terminal_fail_flag_o,
  input wire logic good_block_received_n_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  wire s_n = message_start_strobe_n_o;
  wire p_n = message_in_progress_n_o;
  wire r_n = transfer_request_n_o;
  wire g_n = good_block_received_n_o;
  wire m12 = !mode_16mhz_i;
  logic [4:0] s_lo_r, g_lo_r;
  // pulse widths counted here; long repetitions would bloat the checker
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_lo_r <= 5'h00;
      g_lo_r <= 5'h00;
    end else begin
      s_lo_r <= s_n ? 5'h00 : s_lo_r + {4'h0, s_lo_r != 5'h1F};
      g_lo_r <= g_n ? 5'h00 : g_lo_r + {4'h0, g_lo_r != 5'h1F};
    end
  end
  ////////////////////////////////////////////////////////////////
  a_start_delay: assert property (
    cmd_parity_mid_i && m12 && s_n && p_n |-> ##97 s_n ##1 !s_n)
    else $error("start strobe delay wrong");
  a_strobe_width: assert property (
    $rose(s_n) |-> s_lo_r == (m12 ? 5'h0E : 5'h0A))
    else $error("start strobe width wrong");
  a_bit6_early: assert property (
    $rose(s_n) |-> ##299 !address_o[6])
    else $error("bit six rose too early");
  a_bit6_low: assert property ($rose(s_n) |-> !address_o[6])
    else $error("bit six not low at strobe rise");
  a_inprog_delay: assert property (
    $fell(s_n) && m12 |-> ##79 p_n ##1 !p_n)
    else $error("in progress delay wrong");
  a_count_load: assert property (
    $fell(p_n) |-> ##1 current_word_count_o == $past(cmd_word_count_i))
    else $error("word count not loaded");
  a_req_release: assert property (
    !r_n && !transfer_grant_n_i |-> ##[1:2] r_n)
    else $error("request not released");
  a_bit6_hold: assert property (
    $rose(address_o[6]) |-> r_n && $past(r_n))
    else $error("bit six rose during transfer");
  a_fail_flag: assert property (
    status_sync_mid_i && term_fail_i |-> ##[1:10] terminal_fail_flag_o)
    else $error("fail flag late");
  a_float_oe: assert property (
    address_oe_n_o == (address_float_select_i && transfer_grant_n_i)
    && strobe_oe_n_o == address_oe_n_o)
    else $error("output enable wrong");
  a_block_width: assert property (
    $rose(g_n) |-> g_lo_r == (m12 ? 5'h0E : 5'h0A))
    else $error("good block pulse width wrong");
  a_select_grant: assert property (
    chip_select_n_o == (r_n || transfer_grant_n_i))
    else $error("chip select wrong");
  c_block: cover property ($fell(g_n));
  c_grant: cover property (!r_n && !transfer_grant_n_i);
  c_fast: cover property ($fell(s_n) && mode_16mhz_i);
endmodule

// File: rts_host_model.sv
`timescale 1ns/100ps
module rts_host_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic transfer_request_n_i,
  output logic transfer_grant_n_o
);
  logic [8:0] wait_r;
  // slow grant outlasts the bit six timer on purpose
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wait_r <= 9'h000;
      transfer_grant_n_o <= 1'b1;
    end else if (transfer_request_n_i) begin
      wait_r <= 9'h000;
      transfer_grant_n_o <= 1'b1;
    end else if (wait_r == (slow_i ? 9'h0FA : 9'h002)) begin
      transfer_grant_n_o <= 1'b0;
    end else begin
      wait_r <= wait_r + 9'h001;
    end
  end
endmodule

// File: tb_rt_message_sequencing_timing.sv
`timescale 1ns/100ps
module tb_rt_message_sequencing_timing;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, mode = 1'b0, slow = 1'b0;
  logic tx = 1'b0, last = 1'b0, good = 1'b0, tf = 1'b0, fsel = 1'b0;
  logic [4:0] ev_r = 5'h00, cnt_in = 5'h00, cnt;
  logic [13:0] sa = 14'h0000, addr;
  logic [2:0] st = 3'h0, sts;
  logic strb_n, prog_n, req_n, grant_n, wr, blk_n;
  logic [6:0] cur, prev;
  localparam logic [6:0] RISE_M = 7'h28;
  int miscompares = 0, checks = 0, cyc = 0, e, ex, m;
  int exp_q[$];
  int t_st[2] = '{97, 87}, t_ip[2] = '{80, 59}, t_cx[2] = '{119, 88};
  int t_wr[2] = '{92, 84}, t_tx[2] = '{170, 143}, t_wf[2] = '{97, 88};
  int t_te[2] = '{101, 91}, t_rx[2] = '{152, 123}, t_re[2] = '{336, 326};
  int t_gb[2] = '{323, 317};
  rts_sequencer dut_u (.clk_sys_i, .rst_i, .mode_16mhz_i(mode), .cmd_parity_mid_i(ev_r[0]),
    .cmd_transmit_i(tx), .cmd_word_count_i(cnt_in), .sub_address_i(sa),
    .status_sync_mid_i(ev_r[1]), .status_parity_mid_i(ev_r[2]), .word_sync_mid_i(ev_r[3]),
    .word_parity_mid_i(ev_r[4]), .last_word_i(last), .rx_good_i(good), .term_fail_i(tf),
    .busy_i(st[2]), .service_request_i(st[1]), .subsystem_flag_i(st[0]),
    .transfer_grant_n_i(grant_n), .address_float_select_i(fsel),
    .message_start_strobe_n_o(strb_n), .message_in_progress_n_o(prog_n),
    .address_o(addr), .address_oe_n_o(), .current_word_count_o(cnt),
    .transfer_request_n_o(req_n), .chip_select_n_o(), .write_strobe_o(wr),
    .strobe_oe_n_o(), .terminal_fail_flag_o(), .good_block_received_n_o(blk_n),
    .status_bits_o(sts));
  rts_host_model host_u (.clk_sys_i, .rst_i, .slow_i(slow),
    .transfer_request_n_i(req_n), .transfer_grant_n_o(grant_n));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [13:0] x, input logic [13:0] g);
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", n, x, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // e is the monitor cycle that follows the sampling edge
  task automatic pulse(input int k);
    tick(1);
    ev_r[k] = 1'b1;
    e = cyc + 2;
    tick(1);
    ev_r[k] = 1'b0;
  endtask
  task automatic note(input int code, input int n);
    exp_q.push_back((e + n) * 8 + code);
  endtask
  task automatic start(input logic t);
    tx = t;
    cnt_in = 5'($urandom);
    sa = 14'($urandom);
    st = 3'($urandom);
    tf = 1'($urandom);
    fsel = 1'($urandom);
    pulse(0);
    note(0, t_st[m]);
    note(1, t_st[m] + t_ip[m]);
    if (t) note(2, t_st[m] + t_cx[m]);
    tick(600);
    chk("address", sa | 14'h0040, addr | 14'h0040);
    chk("status", {11'h000, st}, {11'h000, sts});
  endtask
  task automatic tx_msg();
    start(1'b1);
    pulse(1);
    note(3, t_wr[m]);
    note(2, t_tx[m]);
    tick(2000);
    last = 1'b0;
    pulse(3);
    note(2, t_tx[m]);
    tick(190);
    pulse(4);
    tick(2000);
    last = 1'b1;
    pulse(3);
    note(4, t_wf[m]);
    tick(190);
    pulse(4);
    note(5, t_te[m]);
    tick(600);
    // command word transfer leaves the count alone; it stops at zero
    chk("count", {9'h000, (cnt_in > 5'h02) ? cnt_in - 5'h02 : 5'h00}, {9'h000, cnt});
    $display("tx message done mode %0d slow %0d", m, slow);
  endtask
  // extra command mid-message must be ignored: no strobe is noted for it
  task automatic rx_msg(input logic g, input logic extra);
    good = g;
    start(1'b0);
    if (extra) pulse(0);
    pulse(4);
    note(2, t_rx[m]);
    tick(2000);
    pulse(1);
    tick(190);
    pulse(2);
    if (g) note(6, t_gb[m]);
    note(5, t_re[m]);
    tick(600);
    chk("count", {9'h000, (cnt_in > 5'h01) ? cnt_in - 5'h01 : 5'h00}, {9'h000, cnt});
    $display("rx message done mode %0d good %0d", m, g);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(negedge clk_sys_i) begin
    cyc = cyc + 1;
    cur = {blk_n, prog_n, wr, wr, req_n, prog_n, strb_n};
    if (!rst_i)
      for (int i = 0; i < 7; i++)
        if (cur[i] !== prev[i] && cur[i] === RISE_M[i]) begin
          checks++;
          ex = (exp_q.size() > 0) ? exp_q.pop_front() : -1;
          if (ex != cyc * 8 + i) begin
            miscompares++;
            $display("mismatch event expected %0d seen %0d", ex, cyc * 8 + i);
          end
        end
    prev = cur;
  end
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #800000;
    miscompares++;
    $display("mismatch run_time expected finish seen timeout");
    print_verdict();
  end
  initial begin
    void'($urandom(40395));
    for (m = 0; m < 2; m++) begin
      mode = m[0];
      rst_i = 1'b1;
      tick(6);
      rst_i = 1'b0;
      slow = 1'b0;
      tx_msg();
      slow = 1'b1;
      tx_msg();
      slow = 1'b0;
      rx_msg(1'b1, 1'b0);
      rx_msg(1'b0, 1'b1);
    end
    chk("pending", 14'h0000, 14'(exp_q.size()));
    print_verdict();
  end
endmodule
bind rts_sequencer rts_props u_props (.clk_sys_i, .rst_i, .mode_16mhz_i, .cmd_parity_mid_i,
  .status_sync_mid_i, .term_fail_i, .cmd_word_count_i, .transfer_grant_n_i,
  .address_float_select_i, .message_start_strobe_n_o, .message_in_progress_n_o,
  .address_o, .address_oe_n_o, .current_word_count_o, .transfer_request_n_o,
  .chip_select_n_o, .strobe_oe_n_o, .terminal_fail_flag_o, .good_block_received_n_o);
